// [inc/sfr_pkg.sv]
`include "sfr_regs.svh"

package sfr_pkg;

  typedef enum logic [1:0] {
    st_idle,
    st_shift_in,
    st_stream,
    st_hold
  } sfr_state_type;

  typedef struct packed {
    logic [2:0]    sck_sy;
    logic [2:0]    cs_sy;
    logic [1:0]    si_sy;
    logic [1:0]    rstp_sy;
    logic [1:0]    wp_sy;
    sfr_state_type fsm;
    logic          page_large;
    logic [5:0]    bit_cnt;
    logic [30:0]   in_sh;
    logic [7:0]    opcode;
    logic [9:0]    page;
    logic [8:0]    byte_ofs;
    logic [7:0]    out_sh;
    logic [7:0]    nxt_byte;
    logic [2:0]    out_cnt;
    logic          rd_pend;
    logic          mem_rd;
    logic          so;
    logic          so_oe;
    logic          cmd_valid;
    logic [9:0]    cmd_page;
    logic [8:0]    cmd_byte;
    logic [8:0]    cmd_buf;
  } sfr_state_reg_type;

endpackage

// [inc/sfr_regs.svh]
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

// Instruction framing
`define SFR_OPCODE_BITS      6'h08
`define SFR_ADDR_DONE_BITS   6'h20
`define SFR_DUMMY_DONE_BITS  6'h00
`define SFR_OPC_CONT_READ    8'he8

// Address field layout, larger page mode
`define SFR_LG_PAGE_MSB      18
`define SFR_LG_PAGE_LSB      9
`define SFR_LG_BYTE_MSB      8
`define SFR_LG_BYTE_LSB      0

// Address field layout, default page mode
`define SFR_DF_PAGE_MSB      17
`define SFR_DF_PAGE_LSB      8
`define SFR_DF_BYTE_MSB      7
`define SFR_DF_BYTE_LSB      0

// Last byte offset of a page for each page size
`define SFR_LAST_BYTE_LARGE  9'h107
`define SFR_LAST_BYTE_DEF    9'h0ff

// Reset values
`define SFR_RST_PAGE_LARGE   1'h0
`define SFR_RST_SYNC_HIGH    3'h7
`define SFR_RST_PIN_SYNC     2'h3

`endif

// [logic/sfr_core.sv]
// Functional notes
// [R1] Reset pin low aborts any operation and returns the state machine to idle.
// [R2] Device stays in reset while the reset pin is low, resumes when high.
// [R3] Internal power-on reset; reset pin needs no power-up sequencing.
// [R4] Host should tie the reset pin high when unused.
// [R5] Write-protect pin is pulled high, so protection is off when floating.
// [R6] Instructions start on select falling edge, then 8-bit opcode, then address.
// [R7] With select low, each serial clock shifts in the next input bit.
// [R8] Opcode, address and data travel most significant bit first.
// [R9] Exactly three address bytes; leading don't-care bits depend on mode.
// [R10] Larger page mode decodes a 9-bit buffer index.
// [R11] Larger page mode decodes 10-bit page plus 9-bit byte offset.
// [R12] Default page mode decodes an 8-bit buffer index.
// [R13] Default mode uses 18-bit address: 10-bit page, 8-bit byte.
// [R14] Legacy read: opcode E8, three address bytes, four dummy bytes, then data.
// [R15] Continuous read advances an internal address counter with no further input.
// [R16] Host holds select low through the whole continuous read.
// [R17] End of page continues at the next page's first byte without gap.
// [R18] After the last array byte, reading wraps to the first page seamlessly.
// [R19] Select rising edge ends the read and floats the serial output.
// [R20] Continuous read bypasses the buffer and leaves it unchanged.
// [R21] Inputs sampled on serial clock rising edges; outputs change on falling edges.
// [R22] Select high: serial input ignored, serial output floating.
// [R23] Page-size setting defaults to the smaller page and steers all decoding.
// [R24] Instruction cut short by select rising is discarded with no effect.
`timescale 1ns/10ps
`default_nettype none

module sfr_core (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic        wp_pin_n_i,
  input  wire logic        cs_n_i,
  input  wire logic        sck_i,
  input  wire logic        si_i,
  output logic             so_o,
  output logic             so_oe_o,
  input  wire logic        page_cfg_wr_i,
  input  wire logic        page_cfg_large_i,
  output logic             page_large_o,
  output logic             wp_protect_o,
  output logic             mem_rd_o,
  output logic [9:0]       mem_page_o,
  output logic [8:0]       mem_byte_o,
  input  wire logic [7:0]  mem_data_i,
  output logic             cmd_valid_o,
  output logic [7:0]       cmd_opcode_o,
  output logic [9:0]       cmd_page_o,
  output logic [8:0]       cmd_byte_o,
  output logic [8:0]       cmd_buf_o
);

  sfr_pkg::sfr_state_reg_type st_ff;
  sfr_pkg::sfr_state_reg_type nxt_st;

  logic        sck_rise;
  logic        sck_fall;
  logic        cs_fall;
  logic        cs_high;
  logic        si_bit;
  logic [5:0]  cnt_inc;
  logic [23:0] addr_word;
  logic [8:0]  last_byte;
  logic        page_end;
  logic [9:0]  adv_page;
  logic [8:0]  adv_byte;

  always_comb begin
    nxt_st    = st_ff;
    sck_rise  = st_ff.sck_sy[1] & ~st_ff.sck_sy[2];
    sck_fall  = ~st_ff.sck_sy[1] & st_ff.sck_sy[2];
    cs_fall   = ~st_ff.cs_sy[1] & st_ff.cs_sy[2];
    cs_high   = st_ff.cs_sy[1];
    si_bit    = st_ff.si_sy[1];
    cnt_inc   = st_ff.bit_cnt + 6'h01;
    addr_word = {st_ff.in_sh[22:0], si_bit};
    last_byte = st_ff.page_large ? `SFR_LAST_BYTE_LARGE : `SFR_LAST_BYTE_DEF;
    page_end  = st_ff.byte_ofs >= last_byte;
    // Byte counter rolls into the next page; the page counter rolls over at the array end
    adv_byte  = page_end ? 9'h000 : st_ff.byte_ofs + 9'h001; // [R17]
    adv_page  = page_end ? st_ff.page + 10'h001 : st_ff.page; // [R18]

    // Two-stage synchronisers; clock and select add one delay stage for edge detection
    nxt_st.sck_sy  = {st_ff.sck_sy[1:0], sck_i};
    nxt_st.cs_sy   = {st_ff.cs_sy[1:0], cs_n_i};
    nxt_st.si_sy   = {st_ff.si_sy[0], si_i};
    nxt_st.rstp_sy = {st_ff.rstp_sy[0], reset_pin_n_i};
    nxt_st.wp_sy   = {st_ff.wp_sy[0], wp_pin_n_i}; // [R5]

    nxt_st.mem_rd    = 1'b0;
    nxt_st.cmd_valid = 1'b0;
    nxt_st.rd_pend   = st_ff.mem_rd;
    // Array byte arrives the cycle after the fetch strobe, straight from main memory
    if (st_ff.rd_pend) begin
      nxt_st.nxt_byte = mem_data_i; // [R20]
    end

    // Page size setting
    if (page_cfg_wr_i) begin
      nxt_st.page_large = page_cfg_large_i; // [R23]
    end

    unique case (st_ff.fsm)
      sfr_pkg::st_idle: begin
        nxt_st.so_oe = 1'b0;
        if (cs_fall) begin
          nxt_st.fsm     = sfr_pkg::st_shift_in; // [R6]
          nxt_st.bit_cnt = 6'h00;
        end
      end
      sfr_pkg::st_shift_in: begin
        if (sck_rise) begin
          // Bits enter at the bottom so the first bit ends up most significant
          nxt_st.in_sh   = {st_ff.in_sh[29:0], si_bit}; // [R7] [R8] [R21]
          nxt_st.bit_cnt = cnt_inc;
          if (cnt_inc == `SFR_OPCODE_BITS) begin
            nxt_st.opcode = {st_ff.in_sh[6:0], si_bit}; // [R6]
          end
          if (cnt_inc == `SFR_ADDR_DONE_BITS) begin
            // Three address bytes complete; strip leading don't-care bits by mode
            if (st_ff.page_large) begin
              nxt_st.cmd_page = addr_word[`SFR_LG_PAGE_MSB:`SFR_LG_PAGE_LSB]; // [R11]
              nxt_st.cmd_byte = addr_word[`SFR_LG_BYTE_MSB:`SFR_LG_BYTE_LSB]; // [R11]
              nxt_st.cmd_buf  = addr_word[8:0]; // [R10]
            end else begin
              nxt_st.cmd_page = addr_word[`SFR_DF_PAGE_MSB:`SFR_DF_PAGE_LSB]; // [R13]
              nxt_st.cmd_byte = {1'b0, addr_word[`SFR_DF_BYTE_MSB:`SFR_DF_BYTE_LSB]}; // [R13]
              nxt_st.cmd_buf  = {1'b0, addr_word[7:0]}; // [R12]
            end
            if (st_ff.opcode == `SFR_OPC_CONT_READ) begin
              nxt_st.page     = st_ff.page_large ?
                                addr_word[`SFR_LG_PAGE_MSB:`SFR_LG_PAGE_LSB] :
                                addr_word[`SFR_DF_PAGE_MSB:`SFR_DF_PAGE_LSB]; // [R9]
              nxt_st.byte_ofs = st_ff.page_large ?
                                addr_word[`SFR_LG_BYTE_MSB:`SFR_LG_BYTE_LSB] :
                                {1'b0, addr_word[`SFR_DF_BYTE_MSB:`SFR_DF_BYTE_LSB]}; // [R9]
              nxt_st.mem_rd   = 1'b1;
            end else begin
              // Other instructions are handed on once opcode and address are in
              nxt_st.cmd_valid = 1'b1; // [R24]
              nxt_st.fsm       = sfr_pkg::st_hold;
            end
          end
          // Four dummy bytes done: counter wraps to zero after 64 bits
          if (cnt_inc == `SFR_DUMMY_DONE_BITS) begin
            nxt_st.fsm      = sfr_pkg::st_stream; // [R14]
            nxt_st.out_sh   = st_ff.nxt_byte;
            nxt_st.out_cnt  = 3'h0;
            nxt_st.page     = adv_page;
            nxt_st.byte_ofs = adv_byte;
            nxt_st.mem_rd   = 1'b1;
          end
        end
      end
      sfr_pkg::st_stream: begin
        if (sck_fall) begin
          nxt_st.so      = st_ff.out_sh[7]; // [R8] [R21]
          nxt_st.so_oe   = 1'b1; // [R14]
          nxt_st.out_sh  = {st_ff.out_sh[6:0], 1'b0};
          nxt_st.out_cnt = st_ff.out_cnt + 3'h1; // [R15]
          if (st_ff.out_cnt == 3'h7) begin
            // Next byte was fetched ahead, so page and array crossings add no gap
            nxt_st.out_sh   = st_ff.nxt_byte; // [R17] [R18]
            nxt_st.page     = adv_page; // [R15]
            nxt_st.byte_ofs = adv_byte; // [R15]
            nxt_st.mem_rd   = 1'b1;
          end
        end
      end
      sfr_pkg::st_hold: begin
        nxt_st.so_oe = 1'b0;
      end
    endcase

    // Select high ends any frame and floats the output; partial frames vanish
    if (cs_high) begin
      nxt_st.fsm   = sfr_pkg::st_idle; // [R19] [R22] [R24]
      nxt_st.so_oe = 1'b0; // [R19] [R22]
      nxt_st.so    = 1'b0;
    end

    // Reset pin low: abort and hold idle, keeping the page size setting
    if (!st_ff.rstp_sy[1]) begin
      nxt_st.fsm       = sfr_pkg::st_idle; // [R1] [R2]
      nxt_st.bit_cnt   = 6'h00;
      nxt_st.so        = 1'b0;
      nxt_st.so_oe     = 1'b0;
      nxt_st.mem_rd    = 1'b0;
      nxt_st.cmd_valid = 1'b0;
      nxt_st.out_cnt   = 3'h0;
    end

    // Power-on reset clears everything except the select, reset pin and write-protect synchronisers, which load high
    if (!rst_n_i) begin
      nxt_st            = '0; // [R3]
      nxt_st.cs_sy      = `SFR_RST_SYNC_HIGH;
      nxt_st.rstp_sy    = `SFR_RST_PIN_SYNC;
      nxt_st.wp_sy      = `SFR_RST_PIN_SYNC;
      nxt_st.page_large = `SFR_RST_PAGE_LARGE; // [R23]
    end
  end

  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  assign so_o         = st_ff.so;
  assign so_oe_o      = st_ff.so_oe;
  assign page_large_o = st_ff.page_large;
  assign wp_protect_o = ~st_ff.wp_sy[1];
  assign mem_rd_o     = st_ff.mem_rd;
  assign mem_page_o   = st_ff.page;
  assign mem_byte_o   = st_ff.byte_ofs;
  assign cmd_valid_o  = st_ff.cmd_valid;
  assign cmd_opcode_o = st_ff.opcode;
  assign cmd_page_o   = st_ff.cmd_page;
  assign cmd_byte_o   = st_ff.cmd_byte;
  assign cmd_buf_o    = st_ff.cmd_buf;

endmodule

`default_nettype wire

// [verif/serial_flash_reset_addr_cont_read_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module serial_flash_reset_addr_cont_read_tb_top;
  logic clk_i = 1'h0, rst_n = 1'h0, rstp_n = 1'h1, wp_n = 1'h1, cfg_wr = 1'h0, cfg_lg = 1'h0;
  logic [7:0] mdata = 8'h00;
  wire logic cs_n, sck, si, so, so_oe, pg_lg, wp_pr, mrd, cv;
  wire logic [9:0] mpg, cpg;
  wire logic [8:0] mby, cby, cbf;
  wire logic [7:0] cop;
  int err_count = 0, n_tests = 0, cyc = 0, cv_n = 0;
  logic [7:0] rx[$];
  wire logic so_pin = so_oe ? so : cyc[0];
  sfr_core u_sfr_core (.clk_i(clk_i), .rst_n_i(rst_n), .reset_pin_n_i(rstp_n), .wp_pin_n_i(wp_n),
    .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe), .page_cfg_wr_i(cfg_wr),
    .page_cfg_large_i(cfg_lg), .page_large_o(pg_lg), .wp_protect_o(wp_pr), .mem_rd_o(mrd),
    .mem_page_o(mpg), .mem_byte_o(mby), .mem_data_i(mdata), .cmd_valid_o(cv),
    .cmd_opcode_o(cop), .cmd_page_o(cpg), .cmd_byte_o(cby), .cmd_buf_o(cbf));
  sfr_host_model u_sfr_host_model (.clk_i(clk_i), .so_i(so_pin), .cs_n_o(cs_n), .sck_o(sck),
    .si_o(si));
  function automatic logic [7:0] mdat(input logic [9:0] p, input logic [8:0] b);
    return p[7:0] ^ b[7:0] ^ {p[9:8], 5'h0, b[8]} ^ 8'h5a;
  endfunction
  task automatic close_out();
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) u_sfr_host_model.shift(d[i], q[i]);
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] ad, input int nb);
    logic [7:0] q;
    rx.delete();
    u_sfr_host_model.sel(1'h0);
    xbyte(op, q);
    for (int i = 2; i >= 0; i--) xbyte(ad[i*8+:8], q);
    for (int i = 0; i < nb; i++) begin
      xbyte(8'($urandom), q);
      if (i > 3) rx.push_back(q);
    end
    u_sfr_host_model.sel(1'h1);
  endtask
  task automatic cfg(input logic lg);
    @(negedge clk_i);
    cfg_wr = 1'h1;
    cfg_lg = lg;
    @(negedge clk_i);
    cfg_wr = 1'h0;
    @(negedge clk_i);
    chk("page size", lg, pg_lg);
  endtask
  always #10 clk_i = ~clk_i;
  always @(negedge clk_i) mdata <= mdat(mpg, mby);
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cv === 1'h1) cv_n <= cv_n + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("mismatch cycle limit expected %0d seen %0d", 20000, cyc);
      close_out();
    end
  end
  initial begin
    logic [7:0] op;
    logic [23:0] ad;
    logic [9:0] p;
    logic [8:0] b;
    logic lg;
    int n;
    void'($urandom(85));
    repeat (5) @(negedge clk_i);
    rst_n = 1'h1;
    repeat (5) @(negedge clk_i);
    chk("reset so_oe", 32'h0, so_oe);
    chk("reset page", 32'h0, pg_lg);
    wp_n = 1'h0;
    repeat (5) @(negedge clk_i);
    chk("wp on", 32'h1, wp_pr);
    wp_n = 1'h1;
    repeat (5) @(negedge clk_i);
    chk("wp off", 32'h0, wp_pr);
    $display("end pin test");
    for (int i = 0; i < 8; i++) begin
      lg = i[0];
      op = 8'($urandom);
      ad = 24'($urandom);
      if (op == 8'he8) op = 8'h53;
      cfg(lg);
      n = cv_n;
      frame(op, ad, 0);
      chk("cmd count", n + 1, cv_n);
      chk("opcode", op, cop);
      chk("page", lg ? ad[18:9] : ad[17:8], cpg);
      chk("byte", lg ? ad[8:0] : {1'h0, ad[7:0]}, cby);
      chk("buffer", lg ? ad[8:0] : {1'h0, ad[7:0]}, cbf);
    end
    n = cv_n;
    u_sfr_host_model.sel(1'h0);
    xbyte(8'h53, op);
    xbyte(8'h12, op);
    u_sfr_host_model.sel(1'h1);
    chk("cut frame", n, cv_n);
    $display("end decode test");
    for (int k = 0; k < 2; k++) begin
      lg = k[0];
      p = k ? 10'h005 : 10'h3ff;
      b = k ? 9'h106 : 9'h0fe;
      cfg(lg);
      ad = lg ? {5'h0, p, b} : {6'h0, p, b[7:0]};
      n = cv_n;
      frame(8'he8, ad, 9);
      foreach (rx[j]) begin
        chk("data", mdat(p, b), rx[j]);
        b++;
        if (b > (lg ? 9'h107 : 9'h0ff)) begin
          b = 9'h0;
          p++;
        end
      end
      chk("so released", 32'h0, so_oe);
      chk("stream no cmd", n, cv_n);
    end
    $display("end stream test");
    fork
      frame(8'he8, 24'h0, 8);
      begin
        repeat (600) @(negedge clk_i);
        chk("stream on", 32'h1, so_oe);
        rstp_n = 1'h0;
        repeat (6) @(negedge clk_i);
        chk("reset pin so_oe", 32'h0, so_oe);
        rstp_n = 1'h1;
      end
    join
    chk("after reset pin", 32'h0, so_oe);
    chk("page kept", 32'h1, pg_lg);
    n = cv_n;
    rstp_n = 1'h0;
    frame(8'h53, 24'h012345, 0);
    chk("held in reset", n, cv_n);
    rstp_n = 1'h1;
    repeat (5) @(negedge clk_i);
    frame(8'h53, 24'h012345, 0);
    chk("resumed", n + 1, cv_n);
    chk("resumed page", 32'h91, cpg);
    $display("end reset pin test");
    close_out();
  end
endmodule
`default_nettype wire

// [verif/sfr_core_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module sfr_core_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reset_pin_n_i,
  input wire logic wp_pin_n_i,
  input wire logic cs_n_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic page_cfg_wr_i,
  input wire logic page_cfg_large_i,
  input wire logic page_large_o,
  input wire logic wp_protect_o,
  input wire logic mem_rd_o,
  input wire logic cmd_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_so_quiet; !so_oe_o |-> !so_o; endproperty
  a_so_quiet: assert property (p_so_quiet) else $error("so driven while off");
  property p_cs_end; $rose(cs_n_i) |-> ##[1:8] !so_oe_o; endproperty
  a_cs_end: assert property (p_cs_end) else $error("so not released");
  property p_rst_pin; (!reset_pin_n_i) [*5] |-> !so_oe_o && !cmd_valid_o; endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin ignored");
  property p_wp_on; (!wp_pin_n_i) [*5] |-> wp_protect_o; endproperty
  a_wp_on: assert property (p_wp_on) else $error("protect not set");
  property p_wp_off; wp_pin_n_i [*5] |-> !wp_protect_o; endproperty
  a_wp_off: assert property (p_wp_off) else $error("protect stuck");
  property p_cfg; page_cfg_wr_i |=> page_large_o == $past(page_cfg_large_i); endproperty
  a_cfg: assert property (p_cfg) else $error("page size not loaded");
  property p_cfg_hold; !page_cfg_wr_i |=> $stable(page_large_o); endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("page size drifted");
  property p_rd_gap; mem_rd_o |=> (!mem_rd_o) [*8]; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("fetch too close");
  property p_cmd_one; cmd_valid_o |=> (!cmd_valid_o) [*8]; endproperty
  a_cmd_one: assert property (p_cmd_one) else $error("command repeated");
  c_rd: cover property (mem_rd_o);
  c_cmd: cover property (cmd_valid_o);
  c_end: cover property ($fell(so_oe_o));
endmodule
bind sfr_core sfr_core_monitor u_sfr_core_monitor (
  .clk_i            (clk_i),
  .rst_n_i          (rst_n_i),
  .reset_pin_n_i    (reset_pin_n_i),
  .wp_pin_n_i       (wp_pin_n_i),
  .cs_n_i           (cs_n_i),
  .so_o             (so_o),
  .so_oe_o          (so_oe_o),
  .page_cfg_wr_i    (page_cfg_wr_i),
  .page_cfg_large_i (page_cfg_large_i),
  .page_large_o     (page_large_o),
  .wp_protect_o     (wp_protect_o),
  .mem_rd_o         (mem_rd_o),
  .cmd_valid_o      (cmd_valid_o)
);
`default_nettype wire

// [verif/sfr_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module sfr_host_model (
  input  wire logic clk_i,
  input  wire logic so_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o
);
  logic si_q = 1'h0;
  logic idle_q = 1'h0;
  initial cs_n_o = 1'h1;
  initial sck_o = 1'h0;
  always @(negedge clk_i) idle_q <= ~idle_q;
  assign si_o = cs_n_o ? idle_q : si_q;
  task automatic sel(input logic lvl);
    @(negedge clk_i);
    cs_n_o = lvl;
    repeat (6) @(negedge clk_i);
  endtask
  task automatic shift(input logic b, output logic r);
    si_q = b;
    repeat (4) @(negedge clk_i);
    sck_o = 1'h1;
    repeat (4) @(negedge clk_i);
    r = so_i;
    sck_o = 1'h0;
  endtask
endmodule
`default_nettype wire
